// ==== hw/lpc_consts.svh ====
/*
  Constants of the LED PWM channel control block: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from the package and the top module.
*/
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH

// ****************************************
// Channel count and device address
// ****************************************
`define LPC_NCH        28
`define LPC_DEV_ADDR   5'h0F

// ****************************************
// Register offsets
// ****************************************
`define LPC_OFS_SLEEP  8'h00
`define LPC_OFS_PWM_LO 8'h05
`define LPC_OFS_PWM_HI 8'h20
`define LPC_OFS_COMMIT 8'h25
`define LPC_OFS_CTL_LO 8'h2A
`define LPC_OFS_CTL_HI 8'h45
`define LPC_OFS_GATE   8'h4A
`define LPC_OFS_SRST   8'h4F

// ****************************************
// Field positions and trigger value
// ****************************************
`define LPC_BIT_SSD    0
`define LPC_BIT_GEN    0
`define LPC_BIT_ON     0
`define LPC_SCALE_LSB  1
`define LPC_TRIG_VAL   8'h00

// ****************************************
// Reset values
// ****************************************
`define LPC_RST_SSD    1'b0
`define LPC_RST_GEN    1'b0
`define LPC_RST_PWM    8'h00
`define LPC_RST_CTL    3'h0

// ****************************************
// Timing: PWM step every LPC_PWM_DIV+1 clocks
// ****************************************
`define LPC_PWM_DIV    4'hF

`endif

// ==== hw/lpc_pkg.sv ====
/*
  Types shared by the LED PWM channel control block.
  Assumes lpc_consts.svh is on the include path.
*/
`include "lpc_consts.svh"

package lpc_pkg;

  // ****************************************
  // Channel arrays
  // ****************************************
  typedef logic [`LPC_NCH-1:0][7:0] lpc_pwm_arr_t;
  typedef logic [`LPC_NCH-1:0][2:0] lpc_ctl_arr_t;
  typedef logic [`LPC_NCH-1:0][1:0] lpc_scale_arr_t;

  // ****************************************
  // Serial receiver states and byte phases
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RX   = 4'h2,
    ST_ACK  = 4'h4,
    ST_IGN  = 4'h8
  } lpc_i2c_st_e;

  typedef enum logic [2:0] {
    PH_DEV = 3'h1,
    PH_REG = 3'h2,
    PH_DAT = 3'h4
  } lpc_phase_e;

endpackage

// ==== hw/lpc_wr_if.sv ====
/*
  Write port from the register decoder to the channel bank.
  Assumes one clock; all signals are one-cycle pulses or their payload.
*/
`timescale 1ns/100ps

interface lpc_wr_if;
  logic       pwm_we;
  logic       ctl_we;
  logic       commit;
  logic       clear;
  logic [4:0] idx;
  logic [7:0] data;

  modport src (output pwm_we, ctl_we, commit, clear, idx, data);
  modport snk (input  pwm_we, ctl_we, commit, clear, idx, data);
endinterface

// ==== hw/lpc_sync.sv ====
/*
  Two-flop synchroniser for the pins of the block.
  Assumes asynchronous pin levels; idle value of every pin taken as high.
*/
`timescale 1ns/100ps

module lpc_sync (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Pins in, synchronised levels out
  input  wire logic [4:0] d_i,
  output logic      [4:0] q_o
);

  logic [4:0] meta;
  logic [4:0] next_meta;
  logic [4:0] next_q;

  // First stage feeds only the second stage
  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= 5'h1F;
      q_o  <= 5'h1F;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule // lpc_sync

// ==== hw/lpc_chan_bank.sv ====
/*
  Shadow and active storage for the 28 PWM and channel control registers.
  Assumes one write, commit or clear pulse at a time on the write port.
*/
`timescale 1ns/100ps

module lpc_chan_bank import lpc_pkg::*; (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   srst_i,
  // Write port
  lpc_wr_if.snk       wr,
  // Active copies
  output lpc_pwm_arr_t act_pwm_o,
  output lpc_ctl_arr_t act_ctl_o
);

  lpc_pwm_arr_t sh_pwm;
  lpc_pwm_arr_t next_sh_pwm;
  lpc_ctl_arr_t sh_ctl;
  lpc_ctl_arr_t next_sh_ctl;
  lpc_pwm_arr_t next_act_pwm;
  lpc_ctl_arr_t next_act_ctl;

  // ****************************************
  // Shadow writes, commit and clear
  // ****************************************
  always_comb begin
    next_sh_pwm  = sh_pwm;
    next_sh_ctl  = sh_ctl;
    next_act_pwm = act_pwm_o;
    next_act_ctl = act_ctl_o;
    if (wr.clear) begin
      next_sh_pwm  = '0;
      next_sh_ctl  = '0;
      next_act_pwm = '0;
      next_act_ctl = '0;
    end else begin
      if (wr.pwm_we) begin
        next_sh_pwm[wr.idx] = wr.data;
      end
      if (wr.ctl_we) begin
        next_sh_ctl[wr.idx] = wr.data[2:0];
      end
      // Whole bank moves in one edge so channels never tear
      if (wr.commit) begin
        next_act_pwm = sh_pwm;
        next_act_ctl = sh_ctl;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_pwm    <= '0;
      sh_ctl    <= '0;
      act_pwm_o <= '0;
      act_ctl_o <= '0;
    end else begin
      sh_pwm    <= next_sh_pwm;
      sh_ctl    <= next_sh_ctl;
      act_pwm_o <= next_act_pwm;
      act_ctl_o <= next_act_ctl;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_commit_copies: assert property (
    wr.commit && !wr.clear |=> act_pwm_o == $past(sh_pwm)
      && act_ctl_o == $past(sh_ctl))
    else $error("Commit did not copy the shadow bank");

  a_active_holds: assert property (
    !wr.commit && !wr.clear |=> $stable(act_pwm_o) && $stable(act_ctl_o))
    else $error("Active bank changed without commit");

  a_clear_zeroes: assert property (
    wr.clear |=> sh_pwm == '0 && act_pwm_o == '0 && act_ctl_o == '0)
    else $error("Soft reset left bank data");

endmodule // lpc_chan_bank

// ==== hw/lpc_top.sv ====
/*
  LED PWM channel control: write-only serial slave, register decode,
  shadowed channel bank, PWM generator and shutdown gating.
  Assumes SCL/SDA are open-drain pins resolved outside, and that the
  analog sinks follow led_sink_outputs_o and current_scale_o.
*/
// Notes on behaviour
// - PWM and control writes land in shadow; zero to 25h commits them.
// - Commit copies all 28 PWM and control shadows in one edge.
// - Control bit 0 turns channel on; bits 7:3 unused; resets zero.
// - Control bits 2:1 pick full, half, third or quarter current.
// - Each channel has 256 duty steps from its 8-bit PWM value.
// - Global register 4Ah holds one gate bit at bit 0, resets zero.
// - Writing zero to 4Fh returns every register to its default.
// - Power-up reset loads defaults so no LED lights.
// - Sleep bit of 00h at zero switches all current sources off.
// - Shutdown pin held low forces hardware shutdown.
// - Register contents survive both shutdown modes.
// - Write-only slave; address 01111, two strap bits, then write bit.
// - Each data byte goes to the pointer, which then steps by one.
// - Sleep bit is bit 0 of 00h; one runs, reset value zero.
`timescale 1ns/100ps
`include "lpc_consts.svh"

module lpc_top import lpc_pkg::*; (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // Serial bus pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  // Address straps and shutdown pin
  input  wire logic [1:0]           ad_i,
  input  wire logic                 hw_sleep_pin_n_i,
  // Channel drive
  output logic      [`LPC_NCH-1:0]  led_sink_outputs_o,
  output lpc_scale_arr_t            current_scale_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [1:0] ad);
    addr_hit = (b[7:3] == `LPC_DEV_ADDR) && (b[2:1] == ad) && !b[0];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       pin_ok;
  logic [1:0] ad_s;

  lpc_sync u_sync (
    .clk_i (clk_i),
    .srst_i(srst_i),
    .d_i   ({scl_i, sda_i, hw_sleep_pin_n_i, ad_i}),
    .q_o   (pins_s)
  );

  assign scl_s  = pins_s[4];
  assign sda_s  = pins_s[3];
  assign pin_ok = pins_s[2];
  assign ad_s   = pins_s[1:0];

  // ****************************************
  // Serial receiver
  // ****************************************
  lpc_i2c_st_e st;
  lpc_i2c_st_e next_st;
  lpc_phase_e  ph;
  lpc_phase_e  next_ph;
  logic [3:0]  bcnt;
  logic [3:0]  next_bcnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        wr_vld;
  logic        next_wr_vld;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  next_wr_data;
  logic        next_sda_oe;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;

  always_comb begin
    next_st      = st;
    next_ph      = ph;
    next_bcnt    = bcnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_wr_vld  = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_sda_oe  = sda_oe_o;
    if (bus_start) begin
      next_st     = ST_RX;
      next_ph     = PH_DEV;
      next_bcnt   = 4'h0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st     = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        ST_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bcnt  = bcnt + 4'h1;
          end else if (scl_fall && bcnt == 4'h8) begin
            next_bcnt   = 4'h0;
            next_st     = ST_ACK;
            next_sda_oe = 1'b1;
            case (ph)
              PH_DEV: begin
                // Foreign address or read request: stay off the bus
                if (!addr_hit(shreg, ad_s)) begin
                  next_st     = ST_IGN;
                  next_sda_oe = 1'b0;
                end
              end
              PH_REG: begin
                next_ptr = shreg;
              end
              default: begin
                next_wr_vld  = 1'b1;
                next_wr_addr = ptr;
                next_wr_data = shreg;
                next_ptr     = ptr + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_st     = ST_RX;
            next_sda_oe = 1'b0;
            next_ph     = (ph == PH_DEV) ? PH_REG : PH_DAT;
          end
        end
        ST_IDLE, ST_IGN: begin
          next_st = st;
        end
        default: begin
          next_st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st       <= ST_IDLE;
      ph       <= PH_DEV;
      bcnt     <= 4'h0;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      wr_vld   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      st       <= next_st;
      ph       <= next_ph;
      bcnt     <= next_bcnt;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      wr_vld   <= next_wr_vld;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      sda_oe_o <= next_sda_oe;
      sda_o    <= 1'b0;
      scl_d    <= scl_s;
      sda_d    <= sda_s;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  lpc_wr_if wr_bus ();

  logic       soft_sleep_n;
  logic       next_ssd;
  logic       gate_off;
  logic       next_gate;
  logic       next_pwm_we;
  logic       next_ctl_we;
  logic       next_commit;
  logic       next_clear;
  logic [4:0] next_idx;
  logic [7:0] next_data;

  always_comb begin
    next_ssd    = soft_sleep_n;
    next_gate   = gate_off;
    next_pwm_we = 1'b0;
    next_ctl_we = 1'b0;
    next_commit = 1'b0;
    next_clear  = 1'b0;
    next_idx    = wr_bus.idx;
    next_data   = wr_bus.data;
    if (wr_vld) begin
      if (wr_addr == `LPC_OFS_SLEEP) begin
        next_ssd = wr_data[`LPC_BIT_SSD];
      end
      if (wr_addr == `LPC_OFS_GATE) begin
        next_gate = wr_data[`LPC_BIT_GEN];
      end
      if (in_range(wr_addr, `LPC_OFS_PWM_LO, `LPC_OFS_PWM_HI)) begin
        next_pwm_we = 1'b1;
        next_idx    = 5'(wr_addr - `LPC_OFS_PWM_LO);
        next_data   = wr_data;
      end
      if (in_range(wr_addr, `LPC_OFS_CTL_LO, `LPC_OFS_CTL_HI)) begin
        next_ctl_we = 1'b1;
        next_idx    = 5'(wr_addr - `LPC_OFS_CTL_LO);
        next_data   = wr_data;
      end
      // Only an all-zero byte triggers; anything else is dropped
      if (wr_addr == `LPC_OFS_COMMIT && wr_data == `LPC_TRIG_VAL) begin
        next_commit = 1'b1;
      end
      if (wr_addr == `LPC_OFS_SRST && wr_data == `LPC_TRIG_VAL) begin
        next_clear = 1'b1;
        next_ssd   = `LPC_RST_SSD;
        next_gate  = `LPC_RST_GEN;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      soft_sleep_n  <= `LPC_RST_SSD;
      gate_off      <= `LPC_RST_GEN;
      wr_bus.pwm_we <= 1'b0;
      wr_bus.ctl_we <= 1'b0;
      wr_bus.commit <= 1'b0;
      wr_bus.clear  <= 1'b0;
      wr_bus.idx    <= 5'h00;
      wr_bus.data   <= 8'h00;
    end else begin
      soft_sleep_n  <= next_ssd;
      gate_off      <= next_gate;
      wr_bus.pwm_we <= next_pwm_we;
      wr_bus.ctl_we <= next_ctl_we;
      wr_bus.commit <= next_commit;
      wr_bus.clear  <= next_clear;
      wr_bus.idx    <= next_idx;
      wr_bus.data   <= next_data;
    end
  end

  // ****************************************
  // Channel bank
  // ****************************************
  lpc_pwm_arr_t act_pwm;
  lpc_ctl_arr_t act_ctl;

  lpc_chan_bank u_bank (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .wr       (wr_bus),
    .act_pwm_o(act_pwm),
    .act_ctl_o(act_ctl)
  );

  // ****************************************
  // PWM timebase and output gating
  // ****************************************
  logic [3:0]          div;
  logic [3:0]          next_div;
  logic [7:0]          cnt;
  logic [7:0]          next_cnt;
  logic                gates_ok;
  logic [`LPC_NCH-1:0] next_led;
  lpc_scale_arr_t      next_scale;

  // Shutdown only gates the sinks; register state is untouched
  assign gates_ok = soft_sleep_n && !gate_off && pin_ok;

  always_comb begin
    next_div = (div == `LPC_PWM_DIV) ? 4'h0 : div + 4'h1;
    next_cnt = (div == `LPC_PWM_DIV) ? cnt + 8'h01 : cnt;
    for (int i = 0; i < `LPC_NCH; i++) begin
      // Duty 0 stays dark; 255 lights 255 of 256 steps
      next_led[i]   = gates_ok && act_ctl[i][`LPC_BIT_ON]
                      && (cnt < act_pwm[i]);
      next_scale[i] = act_ctl[i][`LPC_SCALE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div                <= 4'h0;
      cnt                <= 8'h00;
      led_sink_outputs_o <= '0;
      current_scale_o    <= '0;
    end else begin
      div                <= next_div;
      cnt                <= next_cnt;
      led_sink_outputs_o <= next_led;
      current_scale_o    <= next_scale;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_bad_trigger;
    wr_vld && wr_data != `LPC_TRIG_VAL
      && (wr_addr == `LPC_OFS_COMMIT || wr_addr == `LPC_OFS_SRST);
  endsequence

  sequence s_ack_end;
    sda_oe_o && st == ST_ACK ##0 scl_fall;
  endsequence

  a_nonzero_ignored: assert property (
    s_bad_trigger |=> !wr_bus.commit && !wr_bus.clear)
    else $error("Nonzero trigger byte took effect");

  a_ack_release: assert property (
    s_ack_end |=> !sda_oe_o && st == ST_RX)
    else $error("Acknowledge not released on falling clock");

  a_ack_addr_match: assert property (
    $rose(sda_oe_o) && ph == PH_DEV |-> addr_hit(shreg, ad_s))
    else $error("Acknowledged a foreign address");

  a_ptr_step: assert property (
    wr_vld |-> ptr == wr_addr + 8'h01)
    else $error("Pointer did not advance after a data byte");

  a_soft_sleep_dark: assert property (
    !soft_sleep_n |=> led_sink_outputs_o == '0)
    else $error("Channel lit in software shutdown");

  a_pin_sleep_dark: assert property (
    !pin_ok |=> led_sink_outputs_o == '0)
    else $error("Channel lit in hardware shutdown");

  a_gate_dark: assert property (
    gate_off |=> led_sink_outputs_o == '0)
    else $error("Channel lit with global gate set");

  a_duty_compare: assert property (
    gates_ok && act_ctl[0][0] |=>
      led_sink_outputs_o[0] == ($past(cnt) < $past(act_pwm[0])))
    else $error("Channel 0 duty compare wrong");

  a_chan_off: assert property (
    !act_ctl[1][0] |=> !led_sink_outputs_o[1])
    else $error("Disabled channel lit");

  a_scale_follow: assert property (
    1'b1 |=> current_scale_o[0] == $past(act_ctl[0][2:1]))
    else $error("Current scale does not follow control bits");

  a_regs_kept: assert property (
    !wr_vld && !gates_ok |=> $stable(soft_sleep_n) && $stable(gate_off))
    else $error("Shutdown changed register contents");

endmodule // lpc_top

// ==== sim/lpc_i2c_host.sv ====
/*
  Write-only serial host model that drives the block's SCL and SDA pins.
  Assumes SDA is resolved outside with a pull-up and fed back on sda_i.
*/
`timescale 1ns/100ps

module lpc_i2c_host (
  // Clock
  input  wire logic clk_i,
  // Bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ****************************************
  // Idle: SCL stands high, SDA released
  // ****************************************
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Phases of 8 clocks keep well clear of the 4-clock minimum
  task automatic pulse(output logic bit_o);
    hold(8);
    scl_o <= 1'b1;
    hold(4);
    bit_o = sda_i;
    hold(4);
    scl_o <= 1'b0;
  endtask

  // ****************************************
  // Frame: START, bytes MSB first, STOP
  // ****************************************
  // SDA moves 2 clocks after SCL falls, so it never looks like START/STOP
  task automatic frame(input logic [7:0] q[$], output int n_ack);
    logic b;
    n_ack = 0;
    sda_low_o <= 1'b1;
    hold(8);
    scl_o <= 1'b0;
    foreach (q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        hold(2);
        sda_low_o <= ~q[i][k];
        pulse(b);
      end
      hold(2);
      sda_low_o <= 1'b0;
      pulse(b);
      n_ack += (b === 1'b0) ? 1 : 0;
    end
    hold(2);
    sda_low_o <= 1'b1;
    hold(8);
    scl_o <= 1'b1;
    hold(8);
    sda_low_o <= 1'b0;
    hold(8);
  endtask
endmodule // lpc_i2c_host

// ==== sim/led_pwm_channel_control_bench.sv ====
/*
  Self-checking bench for the LED PWM channel control block.
  Assumes the host model lpc_i2c_host and the design files under hw/.
*/
`timescale 1ns/100ps
`include "lpc_consts.svh"

module led_pwm_channel_control_bench import lpc_pkg::*; ();
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int         CH[5]    = '{0, 1, 2, 3, `LPC_NCH - 1};
  localparam logic [7:0] ON_D[5]  = '{8'h04, 8'hFF, 8'h80, 8'h00, 8'h80};
  localparam logic [7:0] OFF_D[5] = '{default: 8'h00};
  localparam logic [1:0] SC_D[5]  = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  localparam logic [1:0] SC_0[5]  = '{default: 2'h0};

  logic                clk_i;
  logic                srst_i;
  logic                hw_sleep_pin_n_i;
  logic [1:0]          ad_i;
  logic                scl;
  logic                sda_low;
  logic                sda_o;
  logic                sda_oe_o;
  logic [`LPC_NCH-1:0] leds;
  lpc_scale_arr_t      scale;
  int                  fail_count;
  int                  checked;
  wire logic           sda_line = ~(sda_low | (sda_oe_o & ~sda_o));
  wire logic [7:0]     dev = {`LPC_DEV_ADDR, ad_i, 1'b0};

  lpc_top u_dut (
    .clk_i              (clk_i),
    .srst_i             (srst_i),
    .scl_i              (scl),
    .sda_i              (sda_line),
    .sda_o              (sda_o),
    .sda_oe_o           (sda_oe_o),
    .ad_i               (ad_i),
    .hw_sleep_pin_n_i   (hw_sleep_pin_n_i),
    .led_sink_outputs_o (leds),
    .current_scale_o    (scale)
  );

  lpc_i2c_host u_host (
    .clk_i     (clk_i),
    .sda_i     (sda_line),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  always #5 clk_i = ~clk_i;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] q[$]);
    logic [7:0] f[$];
    int         n;
    f = {dev, q};
    @(posedge clk_i);
    u_host.frame(f, n);
    check("ack count", f.size(), n);
    repeat (8) @(posedge clk_i);
  endtask

  // One PWM period is 4096 clocks, so any such span holds duty*16 on-cycles
  task automatic expect_duty(input logic [7:0] d[5]);
    logic [31:0] cnt[5];
    cnt = '{default: 0};
    repeat (256 * (`LPC_PWM_DIV + 1)) begin
      @(negedge clk_i);
      for (int i = 0; i < 5; i++)
        cnt[i] += leds[CH[i]];
    end
    for (int i = 0; i < 5; i++)
      check("on cycles", d[i] * (`LPC_PWM_DIV + 1), cnt[i]);
  endtask

  task automatic expect_scale(input logic [1:0] s[5]);
    for (int i = 0; i < 5; i++)
      check("scale", s[i], scale[CH[i]]);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    expect_scale(SC_0);
    check("leds", 0, leds);
  endtask

  task automatic t_foreign();
    int n;
    u_host.frame('{{`LPC_DEV_ADDR, ~ad_i, 1'b0}, 8'h00, 8'h01}, n);
    check("foreign ack", 0, n);
    u_host.frame('{dev | 8'h01, 8'h00, 8'h01}, n);
    check("read ack", 0, n);
    check("sda drive level", 0, sda_o);
  endtask

  task automatic t_shadow();
    wr('{`LPC_OFS_SLEEP, 8'h01});
    wr('{`LPC_OFS_PWM_LO, 8'h04, 8'hFF, 8'h80, 8'h80});
    wr('{`LPC_OFS_CTL_LO, 8'h01, 8'h03, 8'h05, 8'h06});
    wr('{`LPC_OFS_PWM_HI, 8'h80});
    wr('{`LPC_OFS_CTL_HI, 8'h07});
    expect_scale(SC_0);
    expect_duty(OFF_D);
    wr('{`LPC_OFS_COMMIT, 8'h01});
    expect_scale(SC_0);
    wr('{`LPC_OFS_COMMIT, 8'h00});
    expect_scale(SC_D);
    expect_duty(ON_D);
  endtask

  task automatic t_gate();
    wr('{`LPC_OFS_GATE, 8'h01});
    expect_duty(OFF_D);
    wr('{`LPC_OFS_GATE, 8'h00});
    expect_duty(ON_D);
  endtask

  task automatic t_sleep();
    wr('{`LPC_OFS_SLEEP, 8'h00});
    expect_duty(OFF_D);
    wr('{`LPC_OFS_SLEEP, 8'h01});
    expect_duty(ON_D);
  endtask

  task automatic t_pin();
    @(posedge clk_i);
    hw_sleep_pin_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    expect_duty(OFF_D);
    @(posedge clk_i);
    hw_sleep_pin_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    expect_duty(ON_D);
  endtask

  task automatic t_srst();
    wr('{`LPC_OFS_SRST, 8'h01});
    expect_duty(ON_D);
    wr('{`LPC_OFS_SRST, 8'h00});
    expect_scale(SC_0);
    wr('{`LPC_OFS_SLEEP, 8'h01});
    wr('{`LPC_OFS_COMMIT, 8'h00});
    expect_duty(OFF_D);
  endtask

  // ****************************************
  // Verdict, main sequence and watchdog
  // ****************************************
  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk_i            = 1'b0;
    srst_i           = 1'b1;
    hw_sleep_pin_n_i = 1'b1;
    ad_i             = 2'b10;
    fail_count       = 0;
    checked          = 0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_foreign();
    t_shadow();
    t_gate();
    t_sleep();
    t_pin();
    t_srst();
    conclude();
  end

  // Whole run needs about 51k clocks; margin kept under the run budget
  initial begin
    repeat (90000) @(posedge clk_i);
    $display("CHECK FAILED watchdog expected done seen hang");
    fail_count++;
    conclude();
  end
endmodule // led_pwm_channel_control_bench
